//--- rtl/sfsp_consts.svh
`ifndef SFSP_CONSTS_SVH
`define SFSP_CONSTS_SVH

// ----------------------------------------------------------------
// Command opcodes
// ----------------------------------------------------------------
`define SFSP_OP_WR_ENABLE  8'h06
`define SFSP_OP_RDSR       8'h05
`define SFSP_OP_SR_WRITE   8'h01
`define SFSP_OP_WIDE_ENTER 8'hB7
`define SFSP_OP_WIDE_EXIT  8'hE9
`define SFSP_OP_READ       8'h03
`define SFSP_OP_FAST_READ  8'h0B

// ----------------------------------------------------------------
// Status and security register layout
// ----------------------------------------------------------------
`define SFSP_SR_LOCK       7
`define SFSP_SR_QUAD       6
`define SFSP_SR_PL_HI      5
`define SFSP_SR_PL_LO      2
`define SFSP_SR_LATCH      1
`define SFSP_SR_BUSY       0
`define SFSP_SEC_WIDE      2
`define SFSP_NV_RESET      6'h00

// ----------------------------------------------------------------
// Array and framing
// ----------------------------------------------------------------
`define SFSP_ARRAY_AW      25
`define SFSP_BYTES_NARROW  3'h3
`define SFSP_BYTES_WIDE    3'h4
`define SFSP_BITS_OPCODE   10'h008
`define SFSP_BITS_STATUS   10'h010

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SFSP_CLK_PERIOD_NS        10
`define SFSP_STATUS_WRITE_TIME_NS 5000
`define SFSP_STATUS_WRITE_CYC \
   ((`SFSP_STATUS_WRITE_TIME_NS + `SFSP_CLK_PERIOD_NS - 1) / `SFSP_CLK_PERIOD_NS)
`define SFSP_HALF_DIV      2'h3

// ----------------------------------------------------------------
// Host register map (byte addresses)
// ----------------------------------------------------------------
`define SFSP_REG_CTRL      5'h00
`define SFSP_REG_TXD       5'h04
`define SFSP_REG_TXX       5'h08
`define SFSP_REG_RXD       5'h0C
`define SFSP_REG_STAT      5'h10
`define SFSP_CTRL_RESET    31'h40000000
`define SFSP_CTRL_START    31
`define SFSP_CTRL_WP       30

`endif

//--- rtl/sfsp_pkg.sv
package sfsp_pkg;
   typedef enum logic [2:0] {
      P_OPC, P_ADDR, P_DUMMY, P_DATA, P_STAT, P_WDAT, P_SKIP
   } sfsp_phase_t;

   typedef enum logic [2:0] {
      H_IDLE, H_SETUP, H_SHIFT, H_HOLD, H_GAP
   } sfsp_hstate_t;
endpackage

//--- rtl/sfsp_link_if.sv
interface sfsp_link_if;
   logic cs_n;
   logic sclk;
   logic si;
   logic so;
   logic wp_n;

   modport dev (input cs_n, input sclk, input si, input wp_n, output so);
   modport host (output cs_n, output sclk, output si, output wp_n, input so);
endinterface

//--- rtl/sfsp_sync.sv
module sfsp_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         ref_clk_i,
   input  wire logic         rst_i,
   // Levels
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta;

   // Idle-high reset keeps a released chip select from looking active.
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta <= '1;
         q_o  <= '1;
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule

//--- rtl/sfsp_device.sv
`include "sfsp_consts.svh"

module sfsp_device (
   // Clock and reset
   input  wire logic      ref_clk_i,
   input  wire logic      rst_i,
   // Serial link
   sfsp_link_if.dev       link,
   // Device state
   output logic     [7:0] status_o,
   output logic     [7:0] security_o,
   output logic           hw_lock_o
);
   logic [3:0]          s_pins;
   logic                s_cs_n;
   logic                s_sclk;
   logic                s_si;
   logic                s_wp_n;
   logic                d_cs_n;
   logic                d_sclk;
   logic                sclk_rise;
   logic                sclk_fall;
   logic                cs_rise;
   logic                byte_end;
   logic [7:0]          new_byte;

   sfsp_pkg::sfsp_phase_t phase;
   logic [7:0]          opcode;
   logic [9:0]          bits;
   logic [6:0]          sh;
   logic [31:0]         addr;
   logic [2:0]          acnt;
   logic [7:0]          wr_byte;
   logic [7:0]          out_byte;
   logic [2:0]          out_idx;

   logic                lock;
   logic                quad;
   logic [3:0]          plevel;
   logic                wr_latch;
   logic                wr_busy;
   logic                wide;
   logic [15:0]         wtimer;
   logic                hw_lock;
   logic                wen_done;
   logic                swr_done;
   logic                wide_on;
   logic                wide_off;
   logic [2:0]          addr_last;
   logic [31:0]         amask;
   logic [31:0]         addr_in;
   logic [31:0]         addr_next;
   logic [7:0]          status;

   // ----------------------------------------------------------------
   // Pin synchronisation and edge detection
   // ----------------------------------------------------------------
   sfsp_sync #(
      .W (4)
   ) u_sync (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .d_i       ({link.cs_n, link.sclk, link.si, link.wp_n}),
      .q_o       (s_pins)
   );

   assign s_cs_n = s_pins[3];
   assign s_sclk = s_pins[2];
   assign s_si   = s_pins[1];
   assign s_wp_n = s_pins[0];

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         d_cs_n <= 1'b1;
         d_sclk <= 1'b1;
      end else begin
         d_cs_n <= s_cs_n;
         d_sclk <= s_sclk;
      end
   end

   assign sclk_rise = s_sclk & ~d_sclk & ~s_cs_n;
   assign sclk_fall = ~s_sclk & d_sclk & ~s_cs_n;
   assign cs_rise   = s_cs_n & ~d_cs_n;
   assign byte_end  = sclk_rise & (bits[2:0] == 3'h7);
   assign new_byte  = {sh, s_si};

   // ----------------------------------------------------------------
   // Protection and addressing
   // ----------------------------------------------------------------
   assign hw_lock   = lock & ~s_wp_n & ~quad;
   assign status    = {lock, quad, plevel, wr_latch, wr_busy};
   assign addr_last = wide ? `SFSP_BYTES_WIDE : `SFSP_BYTES_NARROW;
   assign amask     = 32'((64'h1 << `SFSP_ARRAY_AW) - 64'h1);
   assign addr_in   = {addr[23:0], new_byte};
   assign addr_next = (addr + 32'h1) & amask;

   // Array content stands in as a fixed pattern of the address.
   function automatic logic [7:0] array_byte(input logic [31:0] a);
      array_byte = a[7:0] ^ a[15:8] ^ a[23:16] ^ {7'h0, a[24]};
   endfunction

   // ----------------------------------------------------------------
   // Command framing
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         phase    <= sfsp_pkg::P_OPC;
         opcode   <= 8'h00;
         bits     <= 10'h000;
         sh       <= 7'h00;
         addr     <= 32'h0;
         acnt     <= 3'h0;
         wr_byte  <= 8'h00;
         out_byte <= 8'h00;
      end else if (s_cs_n) begin
         phase <= sfsp_pkg::P_OPC;
         bits  <= 10'h000;
         addr  <= 32'h0;
         acnt  <= 3'h0;
      end else if (sclk_rise) begin
         sh <= new_byte[6:0];
         if (bits != 10'h3FF) begin
            bits <= bits + 10'h001;
         end
         if (byte_end) begin
            case (phase)
               sfsp_pkg::P_OPC: begin
                  opcode <= new_byte;
                  case (new_byte)
                     `SFSP_OP_RDSR: begin
                        phase    <= sfsp_pkg::P_STAT;
                        out_byte <= status;
                     end
                     `SFSP_OP_READ: begin
                        phase <= sfsp_pkg::P_ADDR;
                     end
                     `SFSP_OP_FAST_READ: begin
                        phase <= wr_busy ? sfsp_pkg::P_SKIP : sfsp_pkg::P_ADDR;
                     end
                     `SFSP_OP_SR_WRITE: begin
                        phase <= sfsp_pkg::P_WDAT;
                     end
                     default: begin
                        phase <= sfsp_pkg::P_SKIP;
                     end
                  endcase
               end
               sfsp_pkg::P_ADDR: begin
                  addr <= addr_in;
                  acnt <= acnt + 3'h1;
                  if (acnt + 3'h1 == addr_last) begin
                     if (opcode == `SFSP_OP_FAST_READ) begin
                        phase <= sfsp_pkg::P_DUMMY;
                     end else begin
                        phase    <= sfsp_pkg::P_DATA;
                        out_byte <= array_byte(addr_in & amask);
                     end
                  end
               end
               sfsp_pkg::P_DUMMY: begin
                  phase    <= sfsp_pkg::P_DATA;
                  out_byte <= array_byte(addr & amask);
               end
               sfsp_pkg::P_DATA: begin
                  addr     <= addr_next;
                  out_byte <= array_byte(addr_next);
               end
               sfsp_pkg::P_STAT: begin
                  out_byte <= status;
               end
               sfsp_pkg::P_WDAT: begin
                  wr_byte <= new_byte;
                  phase   <= sfsp_pkg::P_SKIP;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Serial output
   // ----------------------------------------------------------------
   // The bit index wraps from 0 to 7 by itself, so each byte boundary
   // lines up without a reload.
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         link.so <= 1'b0;
         out_idx <= 3'h7;
      end else if (s_cs_n) begin
         link.so <= 1'b0;
         out_idx <= 3'h7;
      end else if (sclk_fall &&
                   (phase == sfsp_pkg::P_DATA || phase == sfsp_pkg::P_STAT)) begin
         link.so <= out_byte[out_idx];
         out_idx <= out_idx - 3'h1;
      end
   end

   // ----------------------------------------------------------------
   // Commands completed by chip select rising
   // ----------------------------------------------------------------
   assign wen_done = cs_rise && opcode == `SFSP_OP_WR_ENABLE &&
                     bits == `SFSP_BITS_OPCODE;
   assign swr_done = cs_rise && opcode == `SFSP_OP_SR_WRITE &&
                     bits == `SFSP_BITS_STATUS &&
                     wr_latch && !wr_busy && !hw_lock;
   assign wide_on  = cs_rise && opcode == `SFSP_OP_WIDE_ENTER &&
                     bits == `SFSP_BITS_OPCODE;
   assign wide_off = cs_rise && opcode == `SFSP_OP_WIDE_EXIT &&
                     bits == `SFSP_BITS_OPCODE;

   // ----------------------------------------------------------------
   // Status register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         {lock, quad, plevel} <= `SFSP_NV_RESET;
      end else if (swr_done) begin
         {lock, quad, plevel} <= wr_byte[`SFSP_SR_LOCK:`SFSP_SR_PL_LO];
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_busy <= 1'b0;
         wtimer  <= 16'h0;
      end else if (swr_done) begin
         wr_busy <= 1'b1;
         wtimer  <= 16'(`SFSP_STATUS_WRITE_CYC - 1);
      end else if (wr_busy) begin
         if (wtimer == 16'h0) begin
            wr_busy <= 1'b0;
         end else begin
            wtimer <= wtimer - 16'h1;
         end
      end
   end

   // A write enable finishing in the cycle the timed write ends wins.
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_latch <= 1'b0;
      end else if (wen_done) begin
         wr_latch <= 1'b1;
      end else if (wr_busy && wtimer == 16'h0) begin
         wr_latch <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Address mode
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wide <= 1'b0;
      end else if (wide_on) begin
         wide <= 1'b1;
      end else if (wide_off) begin
         wide <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // No program or erase path exists here; the level bits and the lock
   // flag are handed out for the array guard that would use them.
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         hw_lock_o <= 1'b0;
      end else begin
         hw_lock_o <= hw_lock;
      end
   end

   assign status_o   = status;
   assign security_o = {5'h00, wide, 2'h0};
endmodule

//--- rtl/sfsp_host.sv
`include "sfsp_consts.svh"

module sfsp_host (
   // Clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   // Avalon-MM slave
   input  wire logic [4:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   // Serial link
   sfsp_link_if.host        link
);
   sfsp_pkg::sfsp_hstate_t state;
   logic [30:0]  cfg;
   logic [31:0]  txd;
   logic [7:0]   txx;
   logic [31:0]  rxd;
   logic         rd_ack;
   logic         busy;
   logic         wr_go;
   logic         start;
   logic         so_s;
   logic [1:0]   div;
   logic         tick;
   logic [47:0]  out_sr;
   logic [9:0]   left;
   logic [2:0]   ntx;

   // ----------------------------------------------------------------
   // Register access
   // ----------------------------------------------------------------
   // A start while a frame runs is stalled rather than dropped.
   assign busy  = state != sfsp_pkg::H_IDLE;
   assign avs_waitrequest_o = (avs_read_i & ~rd_ack) |
      (avs_write_i & (avs_address_i == `SFSP_REG_CTRL) &
       avs_writedata_i[`SFSP_CTRL_START] & busy);
   assign wr_go = avs_write_i & ~avs_waitrequest_o;
   assign start = wr_go & (avs_address_i == `SFSP_REG_CTRL) &
                  avs_writedata_i[`SFSP_CTRL_START];

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg <= `SFSP_CTRL_RESET;
         txd <= 32'h0;
         txx <= 8'h00;
      end else if (wr_go) begin
         case (avs_address_i)
            `SFSP_REG_CTRL: cfg <= avs_writedata_i[30:0];
            `SFSP_REG_TXD:  txd <= avs_writedata_i;
            `SFSP_REG_TXX:  txx <= avs_writedata_i[7:0];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_ack         <= 1'b0;
         avs_readdata_o <= 32'h0;
      end else begin
         rd_ack <= avs_read_i & ~rd_ack;
         if (avs_read_i & ~rd_ack) begin
            case (avs_address_i)
               `SFSP_REG_CTRL: avs_readdata_o <= {1'b0, cfg};
               `SFSP_REG_TXD:  avs_readdata_o <= txd;
               `SFSP_REG_TXX:  avs_readdata_o <= {24'h0, txx};
               `SFSP_REG_RXD:  avs_readdata_o <= rxd;
               `SFSP_REG_STAT: avs_readdata_o <= {31'h0, busy};
               default:        avs_readdata_o <= 32'h0;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Serial engine
   // ----------------------------------------------------------------
   sfsp_sync #(
      .W (1)
   ) u_sync (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .d_i       (link.so),
      .q_o       (so_s)
   );

   assign ntx  = (avs_writedata_i[10:8] > 3'h5) ? 3'h5 : avs_writedata_i[10:8];
   assign tick = div == `SFSP_HALF_DIV;

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         div <= 2'h0;
      end else if (!busy || tick) begin
         div <= 2'h0;
      end else begin
         div <= div + 2'h1;
      end
   end

   // Serial-out is sampled late in the high phase: the device answers a
   // falling edge only after its own synchroniser delay.
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state     <= sfsp_pkg::H_IDLE;
         link.cs_n <= 1'b1;
         link.sclk <= 1'b0;
         out_sr    <= 48'h0;
         left      <= 10'h000;
         rxd       <= 32'h0;
      end else begin
         case (state)
            sfsp_pkg::H_IDLE: begin
               if (start) begin
                  state     <= sfsp_pkg::H_SETUP;
                  link.cs_n <= 1'b0;
                  out_sr    <= {avs_writedata_i[7:0],
                                {txx, txd} << (6'(5 - ntx) * 6'h8)};
                  left      <= 10'h008 + {4'h0, ntx, 3'h0} +
                               {7'h00, avs_writedata_i[13:11]} +
                               {1'b0, avs_writedata_i[19:14], 3'h0};
               end
            end
            sfsp_pkg::H_SETUP: begin
               if (tick) begin
                  state <= sfsp_pkg::H_SHIFT;
               end
            end
            sfsp_pkg::H_SHIFT: begin
               if (tick) begin
                  link.sclk <= ~link.sclk;
                  if (link.sclk) begin
                     rxd    <= {rxd[30:0], so_s};
                     out_sr <= out_sr << 1;
                     left   <= left - 10'h001;
                     if (left == 10'h001) begin
                        state <= sfsp_pkg::H_HOLD;
                     end
                  end
               end
            end
            sfsp_pkg::H_HOLD: begin
               if (tick) begin
                  link.cs_n <= 1'b1;
                  state     <= sfsp_pkg::H_GAP;
               end
            end
            sfsp_pkg::H_GAP: begin
               if (tick) begin
                  state <= sfsp_pkg::H_IDLE;
               end
            end
            default: begin
               state <= sfsp_pkg::H_IDLE;
            end
         endcase
      end
   end

   assign link.si   = out_sr[47];
   assign link.wp_n = cfg[`SFSP_CTRL_WP];
endmodule

//--- verif/sfsp_sva.sv
module sfsp_sva (
   // Clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       rst_i,
   // Link
   input  wire logic       cs_n,
   input  wire logic       sclk,
   input  wire logic       so,
   input  wire logic       wp_n,
   // Device state
   input  wire logic [7:0] status_o,
   input  wire logic [7:0] security_o,
   input  wire logic       hw_lock_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] busy_cnt;

   // Counts busy cycles so that the write time can be checked at its end.
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) busy_cnt <= 10'h000;
      else if (status_o[0]) busy_cnt <= busy_cnt + 10'h001;
      else busy_cnt <= 10'h000;
   end

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   property p_so_fall; !cs_n && $changed(so) |-> !sclk; endproperty
   a_so_fall: assert property (p_so_fall) else $error("data out moved in high phase");
   property p_so_idle; cs_n [*6] |-> !so; endproperty
   a_so_idle: assert property (p_so_idle) else $error("data out busy after frame");
   property p_busy_len; $fell(status_o[0]) |-> busy_cnt == 10'h1F4; endproperty
   a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
   property p_latch_clr; $fell(status_o[0]) |-> !status_o[1]; endproperty
   a_latch_clr: assert property (p_latch_clr) else $error("latch kept after write");
   property p_busy_start; $rose(status_o[0]) |-> cs_n && status_o[1]; endproperty
   a_busy_start: assert property (p_busy_start) else $error("write without latch");
   property p_latch_set; $rose(status_o[1]) |-> cs_n; endproperty
   a_latch_set: assert property (p_latch_set) else $error("latch set inside frame");
   property p_hw_on; (status_o[7] && !status_o[6] && !wp_n) [*4] |-> hw_lock_o; endproperty
   a_hw_on: assert property (p_hw_on) else $error("hardware lock missing");
   property p_hw_off; (wp_n || status_o[6]) [*4] |-> !hw_lock_o; endproperty
   a_hw_off: assert property (p_hw_off) else $error("hardware lock stuck");
   property p_frozen; hw_lock_o |=> $stable(status_o[7:2]); endproperty
   a_frozen: assert property (p_frozen) else $error("locked bits changed");
   property p_wide; $changed(security_o[2]) |-> cs_n; endproperty
   a_wide: assert property (p_wide) else $error("wide flag moved in frame");

   c_write: cover property ($fell(status_o[0]));
   c_lock: cover property (hw_lock_o);
   c_wide: cover property ($rose(security_o[2]));
endmodule

//--- verif/tb.sv
`include "sfsp_consts.svh"

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [4:0]  adr = 5'h00;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdata;
   logic        wreq;
   logic [7:0]  status_o;
   logic [7:0]  security_o;
   logic        hw_lock_o;
   logic        wp = 1'b1;
   logic [5:0]  st = 6'h00;
   logic [31:0] v;
   logic [31:0] a;
   logic [63:0] t;
   int          failures = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   integer      seed = 32'hb25b;

   sfsp_link_if link_if ();
   sfsp_device sfsp_device_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link_if),
      .status_o(status_o), .security_o(security_o), .hw_lock_o(hw_lock_o));
   sfsp_host sfsp_host_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wreq), .link(link_if));
   sfsp_sva sfsp_sva_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .cs_n(link_if.cs_n),
      .sclk(link_if.sclk), .so(link_if.so), .wp_n(link_if.wp_n), .status_o(status_o),
      .security_o(security_o), .hw_lock_o(hw_lock_o));

   always #5 ref_clk_i = ~ref_clk_i;

   // ----------------------------------------------------------------
   // Model and checks
   // ----------------------------------------------------------------
   function automatic logic [7:0] arr(input logic [31:0] x);
      return x[7:0] ^ x[15:8] ^ x[23:16] ^ {7'h00, x[24]};
   endfunction

   task automatic chk_rx(input logic [31:0] g, input logic [31:0] x);
      samples_checked++;
      if (g !== x) begin
         failures++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask

   task automatic chk_pin(input logic [7:0] g, input logic [7:0] x);
      samples_checked++;
      if (g !== x) begin
         failures++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask

   task automatic end_sim;
      $display("checked=%0d failures=%0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Bus and frame tasks
   // ----------------------------------------------------------------
   // The trailing edge keeps two requests from being set in one time step.
   task automatic av_wr(input logic [4:0] ad, input logic [31:0] d);
      adr <= ad;
      wd <= d;
      wr <= 1'b1;
      @(posedge ref_clk_i iff wreq === 1'b0);
      wr <= 1'b0;
      @(posedge ref_clk_i);
   endtask

   task automatic av_rd(input logic [4:0] ad, output logic [31:0] d);
      adr <= ad;
      rd <= 1'b1;
      @(posedge ref_clk_i iff wreq === 1'b0);
      d = rdata;
      rd <= 1'b0;
      @(posedge ref_clk_i);
   endtask

   task automatic frame(input logic [7:0] op, input logic [2:0] n, input logic [2:0] ex,
                        input logic [5:0] rx, input logic [63:0] tv, output logic [31:0] r);
      av_wr(`SFSP_REG_TXD, tv[31:0]);
      av_wr(`SFSP_REG_TXX, tv[63:32]);
      av_wr(`SFSP_REG_CTRL, {1'b1, wp, 10'h000, rx, ex, n, op});
      r = 32'h1;
      while (r[0] === 1'b1) av_rd(`SFSP_REG_STAT, r);
      av_rd(`SFSP_REG_RXD, r);
   endtask

   task automatic idle(output logic [31:0] r);
      r = 32'h1;
      for (int i = 0; i < 20 && r[0] !== 1'b0; i++)
         frame(`SFSP_OP_RDSR, 3'h0, 3'h0, 6'h02, 64'h0, r);
   endtask

   task automatic sr_write(input logic [7:0] d, input logic [2:0] ex, input logic we,
                           input logic ok);
      if (we) frame(`SFSP_OP_WR_ENABLE, 3'h0, 3'h0, 6'h00, 64'h0, v);
      frame(`SFSP_OP_SR_WRITE, 3'h1, ex, 6'h00, {56'h0, d}, v);
      frame(`SFSP_OP_RDSR, 3'h0, 3'h0, 6'h02, 64'h0, v);
      chk_rx({30'h0, v[1:0]}, {30'h0, we, ok});
      if (ok) st = d[7:2];
      idle(v);
      chk_rx({16'h0, v[15:0]}, {16'h0, {2{st, we & ~ok, 1'b0}}});
      chk_pin(status_o, {st, we & ~ok, 1'b0});
   endtask

   task automatic setwp(input logic b, input logic hw);
      wp = b;
      av_wr(`SFSP_REG_CTRL, {1'b0, b, 30'h0});
      repeat (6) @(posedge ref_clk_i);
      chk_pin({7'h00, hw_lock_o}, {7'h00, hw});
   endtask

   // A hang would otherwise run forever; the ceiling is several times the expected run.
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         failures++;
         end_sim;
      end
   end

   initial begin
      repeat (3) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      chk_pin(status_o, 8'h00);
      chk_pin(security_o, 8'h00);
      sr_write(8'hFF, 3'h0, 1'b0, 1'b0);
      for (int i = 0; i < 3; i++) sr_write(8'($random(seed)), 3'h0, 1'b1, 1'b1);
      sr_write(8'h3C, 3'h3, 1'b1, 1'b0);
      $display("test status_write done");
      sr_write(8'h80, 3'h0, 1'b1, 1'b1);
      setwp(1'b0, 1'b1);
      sr_write(8'h00, 3'h0, 1'b1, 1'b0);
      setwp(1'b1, 1'b0);
      sr_write(8'hC0, 3'h0, 1'b1, 1'b1);
      setwp(1'b0, 1'b0);
      sr_write(8'h00, 3'h0, 1'b1, 1'b1);
      setwp(1'b1, 1'b0);
      $display("test protection done");
      for (int m = 1; m >= 0; m--) begin
         frame(m ? `SFSP_OP_WIDE_ENTER : `SFSP_OP_WIDE_EXIT, 3'h0, 3'h0, 6'h00, 64'h0, v);
         chk_pin(security_o, m ? 8'h04 : 8'h00);
         for (int k = 0; k < 4; k++) begin
            a = (k < 2) ? 32'h01FFFFFE : $random(seed);
            if (m == 0) a[31:24] = 8'h00;
            t = {32'h0, a} << (8 * (k % 2));
            frame((k % 2) ? `SFSP_OP_FAST_READ : `SFSP_OP_READ, 3'(3 + m + k % 2), 3'h0,
                  6'h04, t, v);
            chk_rx(v, {arr(a), arr(a + 1), arr(a + 2), arr(a + 3)});
         end
      end
      $display("test read done");
      frame(`SFSP_OP_WR_ENABLE, 3'h0, 3'h0, 6'h00, 64'h0, v);
      frame(`SFSP_OP_SR_WRITE, 3'h1, 3'h0, 6'h00, 64'h0, v);
      a = {8'h00, 24'($random(seed))};
      frame(`SFSP_OP_FAST_READ, 3'h4, 3'h0, 6'h01, {32'h0, a} << 8, v);
      chk_rx(v, 32'h0);
      frame(`SFSP_OP_READ, 3'h3, 3'h0, 6'h04, {32'h0, a}, v);
      chk_rx(v, {arr(a), arr(a + 1), arr(a + 2), arr(a + 3)});
      idle(v);
      chk_pin(status_o, {st, 2'b00});
      $display("test busy done");
      end_sim;
   end
endmodule
